// ===== hw/pll_limp_home_ctrl.sv
// PLL lock status, filter mode control and limp-home supervision
`timescale 1ns/1ps

module pll_limp_home_ctrl (
    input wire logic pclk, // Bus clock
    input wire logic presetn, // Async reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [7:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error, unmapped address
    input wire logic pll_supply, // PLL supply present, async
    input wire logic normal_mode, // Normal operating mode strap, async
    input wire logic vco_locked, // Analog lock comparator, async
    input wire logic vco_tracking, // Analog tracking comparator, async
    input wire logic external_clock_input, // Monitor result: clock present, async
    output logic pll_power_enable, // PLL power enable
    output logic filter_tracking_select, // Filter mode, 1 tracking
    output logic bus_clock_from_pll_select, // Bus clock from PLL
    output logic module_clock_select, // Module clock select
    output logic forced_clock_monitor_enable, // Monitor enable to analog
    output logic limp_home_status_flag, // Running on VCO minimum
    output logic vco_min_clock_select, // Timing, debug, module clocks from VCO
    output logic internal_reset_n, // Internal reset, active low
    output logic monitor_reset_req, // Clock monitor reset request
    output logic lock_irq, // Lock change interrupt
    output logic limp_home_irq // Limp-home interrupt
);
    import pll_lh_pkg::*;

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic [4:0] async_in;
    logic [4:0] sync1_r;
    logic [4:0] sync2_r;
    assign async_in = {external_clock_input, vco_tracking, vco_locked, normal_mode, pll_supply};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_r <= 5'h00;
            sync2_r <= 5'h00;
        end else begin
            sync1_r <= async_in;
            sync2_r <= sync1_r;
        end
    end

    logic supply_s;
    logic normal_s;
    logic locked_s;
    logic tracking_s;
    logic ext_s;
    assign supply_s = sync2_r[0];
    assign normal_s = sync2_r[1];
    assign locked_s = sync2_r[2];
    assign tracking_s = sync2_r[3];
    assign ext_s = sync2_r[4];

    // ------------------------------------------------------------
    // State machine
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_RESET = 2'b00,
        ST_RESET_EXT = 2'b01,
        ST_RUN = 2'b10
    } phase_t;
    phase_t phase_r;

    logic [9:0] ctrl_r;
    logic lockif_r;
    logic limp_home_irq_flag_r;
    logic lock_r;
    logic limp_home_status_flag_r;
    logic [12:0] cnt_r;
    logic mid_hit;
    logic lh_allowed;
    logic mon_on;
    logic wr_en;
    logic rd_en;
    logic addr_ok;

    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && !penable && !pwrite;
    assign addr_ok = (paddr == CTRL_OFS) || (paddr == FLAG_OFS) || (paddr == STAT_OFS);
    assign mid_hit = (cnt_r == MID_COUNT);
    assign lh_allowed = supply_s && !ctrl_r[NOLH_BIT];
    assign mon_on = ctrl_r[CME_BIT] || ctrl_r[FORCED_CLOCK_MONITOR_ENABLE_BIT] || limp_home_status_flag_r;

    // ------------------------------------------------------------
    // 13-stage free-running counter
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= CNT_ZERO;
        end else if (phase_r == ST_RESET && ext_s) begin
            cnt_r <= CNT_ZERO;
        end else if (phase_r == ST_RESET_EXT && mid_hit) begin
            cnt_r <= CNT_ZERO;
        end else begin
            cnt_r <= cnt_r + 13'h0001;
        end
    end

    // ------------------------------------------------------------
    // Reset phase and limp-home status
    // ------------------------------------------------------------
    logic limp_home_status_flag_nxt;
    always_comb begin
        limp_home_status_flag_nxt = limp_home_status_flag_r;
        unique case (phase_r)
            ST_RESET: begin
                if (ext_s || !supply_s) begin
                    limp_home_status_flag_nxt = 1'b0;
                end else if (mid_hit) begin
                    limp_home_status_flag_nxt = normal_s;
                end
            end
            ST_RESET_EXT: begin
                limp_home_status_flag_nxt = 1'b0;
            end
            ST_RUN: begin
                if (limp_home_status_flag_r) begin
                    if (mid_hit && ext_s) begin
                        limp_home_status_flag_nxt = 1'b0;
                    end
                end else if (!ext_s && mon_on && lh_allowed) begin
                    limp_home_status_flag_nxt = 1'b1;
                end
            end
            default: begin
                limp_home_status_flag_nxt = 1'b0;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_r <= ST_RESET;
        end else begin
            unique case (phase_r)
                ST_RESET: begin
                    if (ext_s) begin
                        phase_r <= ST_RESET_EXT;
                    end else if (mid_hit) begin
                        phase_r <= ST_RUN;
                    end
                end
                ST_RESET_EXT: begin
                    if (mid_hit) begin
                        phase_r <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    phase_r <= ST_RUN;
                end
                default: begin
                    phase_r <= ST_RESET;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            limp_home_status_flag_r <= 1'b0;
        end else begin
            limp_home_status_flag_r <= limp_home_status_flag_nxt;
        end
    end

    // ------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= CTRL_RST;
        end else if (wr_en && paddr == CTRL_OFS) begin
            ctrl_r <= pwdata[9:0];
            if (pwdata[AUTO_BIT]) begin
                ctrl_r[TRK_BIT] <= ctrl_r[TRK_BIT];
            end
        end else if (ctrl_r[AUTO_BIT]) begin
            ctrl_r[TRK_BIT] <= tracking_s;
        end
    end

    // ------------------------------------------------------------
    // Lock status and interrupt flags
    // ------------------------------------------------------------
    logic lock_clr;
    logic lh_clr;
    assign lock_clr = wr_en && paddr == FLAG_OFS && pwdata[LOCKIF_BIT];
    assign lh_clr = wr_en && paddr == FLAG_OFS && pwdata[LIMP_HOME_IRQ_FLAG_BIT];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lock_r <= 1'b0;
            lockif_r <= 1'b0;
        end else begin
            lock_r <= locked_s;
            if (lock_r != locked_s) begin
                lockif_r <= 1'b1;
            end else if (lock_clr) begin
                lockif_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            limp_home_irq_flag_r <= 1'b0;
        end else if (limp_home_status_flag_nxt != limp_home_status_flag_r) begin
            limp_home_irq_flag_r <= 1'b1;
        end else if (lh_clr) begin
            limp_home_irq_flag_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Clock control outputs
    // ------------------------------------------------------------
    logic in_reset_nxt;
    assign in_reset_nxt = (phase_r != ST_RUN) && !(phase_r == ST_RESET && mid_hit && !ext_s)
        && !(phase_r == ST_RESET_EXT && mid_hit);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pll_power_enable <= 1'b1;
        end else begin
            pll_power_enable <= ctrl_r[PLL_POWER_ENABLE_BIT] || limp_home_status_flag_nxt;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            filter_tracking_select <= 1'b0;
        end else begin
            filter_tracking_select <= ctrl_r[TRK_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bus_clock_from_pll_select <= 1'b1;
        end else begin
            bus_clock_from_pll_select <= ctrl_r[BUS_CLOCK_FROM_PLL_SELECT_BIT] || limp_home_status_flag_nxt;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            module_clock_select <= 1'b0;
        end else begin
            module_clock_select <= ctrl_r[MCS_BIT] && !limp_home_status_flag_nxt;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            forced_clock_monitor_enable <= 1'b1;
        end else begin
            forced_clock_monitor_enable <= mon_on || limp_home_status_flag_nxt;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            limp_home_status_flag <= 1'b0;
        end else begin
            limp_home_status_flag <= limp_home_status_flag_nxt;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vco_min_clock_select <= 1'b1;
        end else begin
            vco_min_clock_select <= limp_home_status_flag_nxt || (phase_r == ST_RESET && supply_s && !ext_s);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            internal_reset_n <= 1'b0;
        end else begin
            internal_reset_n <= !in_reset_nxt;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            monitor_reset_req <= 1'b0;
        end else begin
            monitor_reset_req <= (phase_r == ST_RUN) && !ext_s && mon_on && !lh_allowed
                && !limp_home_status_flag_r;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lock_irq <= 1'b0;
        end else begin
            lock_irq <= lockif_r && ctrl_r[LOCK_CHANGE_IRQ_ENABLE_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            limp_home_irq <= 1'b0;
        end else begin
            limp_home_irq <= limp_home_irq_flag_r && ctrl_r[LIMP_HOME_IRQ_ENABLE_BIT];
        end
    end

    // ------------------------------------------------------------
    // APB slave, zero wait states
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= psel && !penable;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr <= 1'b0;
        end else begin
            pslverr <= psel && !penable && !addr_ok;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (rd_en) begin
            unique case (paddr)
                CTRL_OFS: prdata <= {22'h000000, ctrl_r};
                FLAG_OFS: prdata <= {28'h0000000, limp_home_status_flag_r, lock_r, limp_home_irq_flag_r, lockif_r};
                STAT_OFS: prdata <= {19'h00000, cnt_r};
                default: prdata <= 32'h00000000;
            endcase
        end
    end
endmodule : pll_limp_home_ctrl

// ===== inc/pll_lh_pkg.sv
// Package: register map, field positions, reset values and timing counts
package pll_lh_pkg;
    // ------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] FLAG_OFS = 8'h04;
    localparam logic [7:0] STAT_OFS = 8'h08;
    // ------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------
    localparam int AUTO_BIT = 0;
    localparam int TRK_BIT = 1;
    localparam int PLL_POWER_ENABLE_BIT = 2;
    localparam int NOLH_BIT = 3;
    localparam int CME_BIT = 4;
    localparam int FORCED_CLOCK_MONITOR_ENABLE_BIT = 5;
    localparam int BUS_CLOCK_FROM_PLL_SELECT_BIT = 6;
    localparam int MCS_BIT = 7;
    localparam int LOCK_CHANGE_IRQ_ENABLE_BIT = 8;
    localparam int LIMP_HOME_IRQ_ENABLE_BIT = 9;
    localparam logic [9:0] CTRL_RST = 10'h055;
    // ------------------------------------------------------------
    // Flag register fields (bits 0 and 1 write one to clear, bits 2 and 3 read-only)
    // ------------------------------------------------------------
    localparam int LOCKIF_BIT = 0;
    localparam int LIMP_HOME_IRQ_FLAG_BIT = 1;
    localparam int LOCK_BIT = 2;
    localparam int LIMP_HOME_STATUS_FLAG_BIT = 3;
    // ------------------------------------------------------------
    // Free-running counter timing
    // ------------------------------------------------------------
    localparam int CNT_STAGES = 13;
    localparam logic [12:0] MID_COUNT = 13'h1000;
    localparam logic [12:0] CNT_ZERO = 13'h0000;
endpackage : pll_lh_pkg

// ===== tb/xtal_model.sv
// Crystal oscillator seen through the clock monitor
`timescale 1ns/1ps
module xtal_model #(
    parameter int STARTUP = 20
) (
    input wire logic pclk, // Clock
    input wire logic powered, // Oscillator running
    output logic clk_ok // Monitor sees clock
);
    int cnt = 0;
    // Start-up delay before the monitor reports a clock
    always @(posedge pclk) begin
        if (!powered) begin
            cnt <= 0;
        end else if (cnt < STARTUP) begin
            cnt <= cnt + 1;
        end
    end
    assign clk_ok = powered && cnt >= STARTUP;
endmodule : xtal_model

// ===== tb/pll_limp_home_ctrl_chk.sv
// Assertion checker for the limp-home controller
`timescale 1ns/1ps
module pll_limp_home_ctrl_chk (
    input wire logic pclk, // Clock
    input wire logic presetn, // Reset
    input wire logic psel, // Select
    input wire logic penable, // Enable
    input wire logic pready, // Ready
    input wire logic pslverr, // Error
    input wire logic pll_supply, // Supply
    input wire logic external_clock_input, // Clock seen
    input wire logic pll_power_enable, // PLL on
    input wire logic bus_clock_from_pll_select, // Bus sel
    input wire logic module_clock_select, // Module sel
    input wire logic forced_clock_monitor_enable, // Monitor on
    input wire logic limp_home_status_flag, // Limp-home
    input wire logic vco_min_clock_select, // VCO clocks
    input wire logic internal_reset_n, // Int reset
    input wire logic monitor_reset_req // Mon reset
);
    logic [13:0] rcnt_r;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Cycles since reset release
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rcnt_r <= 14'h0000;
        end else if (rcnt_r != 14'h3fff) begin
            rcnt_r <= rcnt_r + 14'h0001;
        end
    end
    property p_rst_hold; rcnt_r < 14'h0fa0 |-> !internal_reset_n; endproperty
    property p_rst_rel; rcnt_r == 14'h20d0 |-> internal_reset_n; endproperty
    property p_lh_force;
        limp_home_status_flag |-> pll_power_enable && bus_clock_from_pll_select && !module_clock_select;
    endproperty
    property p_lh_mon; limp_home_status_flag |-> forced_clock_monitor_enable; endproperty
    property p_lh_vco; limp_home_status_flag |-> vco_min_clock_select; endproperty
    property p_loss;
        (internal_reset_n && forced_clock_monitor_enable && !external_clock_input)[*6]
        |-> limp_home_status_flag || monitor_reset_req;
    endproperty
    property p_supply; (!pll_supply)[*6] |-> !limp_home_status_flag; endproperty
    property p_mrq; monitor_reset_req |-> !limp_home_status_flag; endproperty
    property p_ready; psel && !penable |=> pready; endproperty
    property p_err; pslverr |-> pready && psel && penable; endproperty
    a_rst_hold: assert property (p_rst_hold) else $error("internal reset released early");
    a_rst_rel: assert property (p_rst_rel) else $error("internal reset never released");
    a_lh_force: assert property (p_lh_force) else $error("clock selects not forced");
    a_lh_mon: assert property (p_lh_mon) else $error("monitor not forced on");
    a_lh_vco: assert property (p_lh_vco) else $error("module clocks not from vco");
    a_loss: assert property (p_loss) else $error("clock loss ignored");
    a_supply: assert property (p_supply) else $error("limp-home without supply");
    a_mrq: assert property (p_mrq) else $error("reset request in limp-home");
    a_ready: assert property (p_ready) else $error("no ready after setup");
    a_err: assert property (p_err) else $error("error outside access");
    c_lh_in: cover property ($rose(limp_home_status_flag));
    c_lh_out: cover property ($fell(limp_home_status_flag));
    c_mrq: cover property ($rose(monitor_reset_req));
endmodule : pll_limp_home_ctrl_chk
bind pll_limp_home_ctrl pll_limp_home_ctrl_chk pll_limp_home_ctrl_chk_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
    .pll_supply(pll_supply), .external_clock_input(external_clock_input), .pll_power_enable(pll_power_enable),
    .bus_clock_from_pll_select(bus_clock_from_pll_select), .module_clock_select(module_clock_select),
    .forced_clock_monitor_enable(forced_clock_monitor_enable), .limp_home_status_flag(limp_home_status_flag),
    .vco_min_clock_select(vco_min_clock_select), .internal_reset_n(internal_reset_n),
    .monitor_reset_req(monitor_reset_req)
);

// ===== tb/pll_limp_home_ctrl_tb_top.sv
// Testbench for the limp-home controller
`timescale 1ns/1ps
module pll_limp_home_ctrl_tb_top;
    import pll_lh_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic pll_supply = 1'b1;
    logic vco_locked = 1'b0;
    logic vco_tracking = 1'b0;
    logic xtal_on = 1'b0;
    logic [31:0] seed = 32'h00016c76;
    logic [31:0] prdata, q, d;
    logic pready, pslverr, e, ext_ok, pll_power_enable, filter_tracking_select, bus_clock_from_pll_select;
    logic module_clock_select, forced_clock_monitor_enable, limp_home_status_flag, vco_min_clock_select;
    logic internal_reset_n, monitor_reset_req, lock_irq, limp_home_irq;
    int error_cnt = 0;
    int checks = 0;
    int cyc = 0;
    always #5 pclk = ~pclk;
    xtal_model xtal_model_i (.pclk(pclk), .powered(xtal_on), .clk_ok(ext_ok));
    pll_limp_home_ctrl pll_limp_home_ctrl_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pll_supply(pll_supply), .normal_mode(1'b1), .vco_locked(vco_locked), .vco_tracking(vco_tracking),
        .external_clock_input(ext_ok), .pll_power_enable(pll_power_enable),
        .filter_tracking_select(filter_tracking_select), .bus_clock_from_pll_select(bus_clock_from_pll_select),
        .module_clock_select(module_clock_select), .forced_clock_monitor_enable(forced_clock_monitor_enable),
        .limp_home_status_flag(limp_home_status_flag), .vco_min_clock_select(vco_min_clock_select),
        .internal_reset_n(internal_reset_n), .monitor_reset_req(monitor_reset_req), .lock_irq(lock_irq),
        .limp_home_irq(limp_home_irq));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    function automatic logic [31:0] ctl_out(input logic [31:0] v);
        return {28'h0, v[PLL_POWER_ENABLE_BIT], v[TRK_BIT], v[BUS_CLOCK_FROM_PLL_SELECT_BIT], v[MCS_BIT]};
    endfunction : ctl_out
    task cmp(input string nm, input logic [31:0] ex, input logic [31:0] got);
        checks++;
        if (got !== ex) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, ex, got);
        end
    endtask : cmp
    task apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        q = prdata;
        e = pslverr;
        @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task rd(input string nm, input logic [7:0] a, input logic [31:0] ex);
        apb(1'b0, a, 32'h00000000);
        cmp(nm, ex, q);
    endtask : rd
    task wt(input int sel, input logic v, input int lim);
        logic s;
        int n;
        n = 0;
        do begin
            @(negedge pclk);
            n++;
            s = sel == 0 ? internal_reset_n : sel == 1 ? limp_home_status_flag : monitor_reset_req;
        end while (s !== v && n < lim);
        cmp("wait", v, s);
    endtask : wt
    task conclude();
        $display("Mismatches %0d of %0d checks", error_cnt, checks);
        if (error_cnt == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : conclude
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 60000) begin
            error_cnt++;
            conclude();
        end
    end
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        rd("ctrl", CTRL_OFS, {22'h0, CTRL_RST});
        wt(0, 1'b1, 9000);
        rd("flag", FLAG_OFS, 32'h0000000a);
        cmp("force", 32'hd, {pll_power_enable, bus_clock_from_pll_select, module_clock_select, vco_min_clock_select});
        apb(1'b1, CTRL_OFS, 32'h00000015);
        @(negedge pclk);
        cmp("bus_clock_from_pll_select", 32'h1, bus_clock_from_pll_select);
        @(posedge pclk);
        xtal_on <= 1'b1;
        wt(1, 1'b0, 8400);
        cmp("bus_clock_from_pll_select", 32'h0, bus_clock_from_pll_select);
        rd("flag", FLAG_OFS, 32'h00000002);
        apb(1'b1, FLAG_OFS, 32'h00000002);
        rd("flag", FLAG_OFS, 32'h00000000);
        rd("hole", 8'h0c, 32'h00000000);
        cmp("slverr", 32'h1, e);
        repeat (4) begin
            d = rnd() & 32'h000003fe;
            apb(1'b1, CTRL_OFS, d & 32'hfffffffd);
            repeat (20) @(posedge pclk);
            apb(1'b1, CTRL_OFS, d);
            rd("ctrl", CTRL_OFS, d);
            @(negedge pclk);
            cmp("outs", ctl_out(d), {28'h0, pll_power_enable, filter_tracking_select, bus_clock_from_pll_select, module_clock_select});
            cmp("mon", d[CME_BIT] | d[FORCED_CLOCK_MONITOR_ENABLE_BIT], forced_clock_monitor_enable);
        end
        apb(1'b1, CTRL_OFS, 32'h00000114);
        vco_locked <= 1'b1;
        repeat (6) @(negedge pclk);
        cmp("lockirq", 32'h1, lock_irq);
        rd("flag", FLAG_OFS, 32'h00000005);
        apb(1'b1, CTRL_OFS, 32'h00000115);
        vco_tracking <= 1'b1;
        repeat (6) @(posedge pclk);
        rd("ctrl", CTRL_OFS, 32'h00000117);
        apb(1'b1, CTRL_OFS, 32'h00000215);
        xtal_on <= 1'b0;
        wt(1, 1'b1, 20);
        repeat (2) @(negedge pclk);
        cmp("lhirq", 32'h1, limp_home_irq);
        @(posedge pclk);
        xtal_on <= 1'b1;
        wt(1, 1'b0, 8400);
        apb(1'b1, CTRL_OFS, 32'h0000001d);
        xtal_on <= 1'b0;
        wt(2, 1'b1, 20);
        @(posedge pclk);
        presetn <= 1'b0;
        pll_supply <= 1'b0;
        xtal_on <= 1'b1;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        repeat (8500) @(posedge pclk);
        xtal_on <= 1'b0;
        wt(2, 1'b1, 20);
        cmp("limp", 32'h0, limp_home_status_flag);
        conclude();
    end
endmodule : pll_limp_home_ctrl_tb_top
